/* File: dv/corr_far_side.sv */
// far-side model: banked data ram and the port pins
`timescale 1ns/1ps
module corr_far_side (
    input wire CORE_CLK,
    input wire [7:0] RAM_ADDR,
    input wire RAM_WR,
    input wire [7:0] RAM_WDATA,
    output logic [7:0] RAM_RDATA,
    input wire [27:0] PORT_OUT,
    input wire [27:0] PIN_DIR,
    input wire [27:0] PIN_EXT,
    output logic [27:0] PIN_IN
);
    logic [7:0] mem [0:255]; // four banks of general data
    // each cell starts as its inverted address, so misrouting shows
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
    end
    assign RAM_RDATA = mem[RAM_ADDR]; // read data valid in the strobe cycle
    // ram write at the strobe edge
    always @(posedge CORE_CLK) begin
        if (RAM_WR) mem[RAM_ADDR] <= RAM_WDATA;
    end
    // input bits see the outside level, output bits loop back the latch
    assign PIN_IN = (PIN_DIR & PIN_EXT) | (~PIN_DIR & PORT_OUT);
endmodule // corr_far_side

/* File: dv/corr_regs_monitor.sv */
// assertion checker for the core operational register bank
`timescale 1ns/1ps
module corr_regs_monitor #(
    parameter PC_W = 12, // counter width
    parameter OPD_W = 10 // jump operand width
) (
    input wire CORE_CLK,
    input wire RST,
    input wire [5:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] RAM_ADDR,
    input wire RAM_RD,
    input wire PC_STEP,
    input wire PC_JUMP,
    input wire PC_CALL,
    input wire PC_RET,
    input wire PC_ADD,
    input wire [OPD_W-1:0] OPERAND,
    input wire [PC_W-1:0] STACK_TOP,
    input wire STACK_PUSH,
    input wire [PC_W-1:0] STACK_PUSH_ADDR,
    input wire [PC_W-1:0] PC,
    input wire CTRL_PAGE,
    input wire [1:0] BANK_SEL,
    input wire LCD_ENABLE,
    input wire [2:0] LCD_COMMONS,
    input wire [10:0] LCD_FRAME_DIV,
    input wire [3:0] SCAN_DATA
);
    // one clock domain; reset masks every check
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // any request that outranks a plain step
    wire pc_other = PC_RET | PC_JUMP | PC_CALL | PC_ADD | REG_WR;
    a_jump_load: assert property (
        (PC_JUMP || PC_CALL) && !PC_RET |=> PC[9:0] == $past(OPERAND))
        else $error("jump target not loaded");
    a_call_push: assert property (
        PC_CALL |-> STACK_PUSH && STACK_PUSH_ADDR == PC + 12'h001)
        else $error("call push address wrong");
    a_ret_reload: assert property (
        PC_RET |=> PC == $past(STACK_TOP))
        else $error("return did not reload counter");
    a_step_page: assert property (
        PC_STEP && !pc_other |=> PC[11:10] == $past(PC[11:10]))
        else $error("step changed page bits");
    a_step_inc: assert property (
        PC_STEP && !pc_other |=> PC[9:0] == $past(PC[9:0]) + 10'h001)
        else $error("step did not advance by one");
    a_bank_write: assert property (
        REG_WR && REG_ADDR == 6'h04 |=> BANK_SEL == $past(REG_WDATA[7:6]))
        else $error("bank select not taken");
    a_page_write: assert property (
        REG_WR && REG_ADDR == 6'h05 |=> CTRL_PAGE == $past(REG_WDATA[0]))
        else $error("control page not taken");
    a_ram_redirect: assert property (
        REG_RD && REG_ADDR[5:4] != 2'b00 |-> RAM_RD && RAM_ADDR == {BANK_SEL, REG_ADDR})
        else $error("data ram access wrong");
    a_scan_off: assert property (
        !LCD_ENABLE [*2] |-> SCAN_DATA == 4'h0)
        else $error("scan data live while disabled");
    a_frame_third: assert property (
        LCD_COMMONS == 3'h3 |=> LCD_FRAME_DIV % 11'h003 == 11'h000)
        else $error("frame divisor not a multiple of three");
endmodule // corr_regs_monitor
bind corr_regs corr_regs_monitor #(.PC_W(PC_W), .OPD_W(OPD_W)) i_corr_regs_monitor (
    .CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .RAM_ADDR(RAM_ADDR), .RAM_RD(RAM_RD),
    .PC_STEP(PC_STEP), .PC_JUMP(PC_JUMP), .PC_CALL(PC_CALL), .PC_RET(PC_RET),
    .PC_ADD(PC_ADD), .OPERAND(OPERAND), .STACK_TOP(STACK_TOP), .STACK_PUSH(STACK_PUSH),
    .STACK_PUSH_ADDR(STACK_PUSH_ADDR), .PC(PC), .CTRL_PAGE(CTRL_PAGE), .BANK_SEL(BANK_SEL),
    .LCD_ENABLE(LCD_ENABLE), .LCD_COMMONS(LCD_COMMONS), .LCD_FRAME_DIV(LCD_FRAME_DIV),
    .SCAN_DATA(SCAN_DATA));

/* File: dv/test_core_operational_registers.sv */
// self-checking bench for the core operational register bank
`timescale 1ns/1ps
module test_core_operational_registers;
    logic CORE_CLK = 0, RST = 1, REG_WR = 0, REG_RD = 0, FLAG_WE = 0, SLEEPING = 0;
    logic PC_STEP = 0, PC_JUMP = 0, PC_CALL = 0, PC_RET = 0, PC_ADD = 0;
    logic SLEEP_EXEC = 0, WDT_CLEAR_EXEC = 0, WDT_TIMEOUT = 0, RESET_PIN_EVENT = 0;
    logic [5:0] REG_ADDR = 0;
    logic [7:0] REG_WDATA = 0, ACC = 0, cv;
    logic [9:0] OPERAND = 0;
    logic [11:0] STACK_TOP = 0;
    logic [2:0] FLAG_IN = 0, nc;
    logic [27:0] PIN_DIR = 0, PIN_EXT = 0;
    logic [4:0] SCAN_ADDR = 0;
    logic [12:0] pushv; // push strobe and address seen in the call cycle
    wire [7:0] REG_RDATA, RAM_ADDR, RAM_WDATA, RAM_RDATA;
    wire RAM_WR, STACK_PUSH, CTRL_PAGE, LCD_ENABLE, LCD_BIAS_THIRD, LCD_TYPE_B;
    wire [11:0] STACK_PUSH_ADDR, PC;
    wire [27:0] PIN_IN, PORT_OUT;
    wire [1:0] BANK_SEL;
    wire [2:0] LCD_COMMONS;
    wire [10:0] LCD_FRAME_DIV;
    wire [3:0] SCAN_DATA;
    wire [16:0] lcd_o = {LCD_BIAS_THIRD, LCD_ENABLE, LCD_TYPE_B, LCD_COMMONS, LCD_FRAME_DIV};
    int n_fail = 0, comparisons = 0, k;
    int nv [12] = '{256, 280, 304, 232, 172, 188, 204, 156, 128, 140, 152, 116}; // frame N
    logic [3:0] evv [7] = '{4'h2, 4'h1, 4'h8, 4'h1, 4'h2, 4'h4, 4'h4}; // status events
    logic sl [7] = '{0, 0, 0, 0, 0, 1, 0}; // core asleep at the event
    logic [7:0] stx [7] = '{8'h10, 8'h00, 8'h18, 8'h08, 8'h10, 8'h10, 8'h18};
    corr_regs i_corr_regs (.CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .RAM_ADDR(RAM_ADDR), .RAM_WR(RAM_WR), .RAM_RD(), .RAM_WDATA(RAM_WDATA),
        .RAM_RDATA(RAM_RDATA), .PC_STEP(PC_STEP), .PC_JUMP(PC_JUMP), .PC_CALL(PC_CALL),
        .PC_RET(PC_RET), .PC_ADD(PC_ADD), .ACC(ACC), .OPERAND(OPERAND), .STACK_TOP(STACK_TOP),
        .STACK_PUSH(STACK_PUSH), .STACK_PUSH_ADDR(STACK_PUSH_ADDR), .PC(PC), .FLAG_WE(FLAG_WE),
        .FLAG_IN(FLAG_IN), .SLEEP_EXEC(SLEEP_EXEC), .WDT_CLEAR_EXEC(WDT_CLEAR_EXEC),
        .WDT_TIMEOUT(WDT_TIMEOUT), .RESET_PIN_EVENT(RESET_PIN_EVENT), .SLEEPING(SLEEPING),
        .PIN_IN(PIN_IN), .PIN_DIR(PIN_DIR), .PORT_OUT(PORT_OUT), .CTRL_PAGE(CTRL_PAGE),
        .BANK_SEL(BANK_SEL), .LCD_ENABLE(LCD_ENABLE), .LCD_BIAS_THIRD(LCD_BIAS_THIRD),
        .LCD_COMMONS(LCD_COMMONS), .LCD_TYPE_B(LCD_TYPE_B), .LCD_FRAME_DIV(LCD_FRAME_DIV),
        .SCAN_ADDR(SCAN_ADDR), .SCAN_DATA(SCAN_DATA));
    corr_far_side i_corr_far_side (.CORE_CLK(CORE_CLK), .RAM_ADDR(RAM_ADDR), .RAM_WR(RAM_WR),
        .RAM_WDATA(RAM_WDATA), .RAM_RDATA(RAM_RDATA), .PORT_OUT(PORT_OUT), .PIN_DIR(PIN_DIR),
        .PIN_EXT(PIN_EXT), .PIN_IN(PIN_IN));
    // 20 MHz core clock
    initial begin
        forever #25 CORE_CLK = ~CORE_CLK;
    end
    // compare and count, report a mismatch at once
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // verdict and end of run
    task stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one-cycle register write, optionally with a flag update in the same cycle
    task wr(input logic [5:0] a, input logic [7:0] d, input logic f = 1'b0);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        FLAG_WE <= f;
        FLAG_IN <= 3'b010;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
        FLAG_WE <= 1'b0;
    endtask
    // one-cycle register read; data is valid after the sampling edge
    task rd(input logic [5:0] a, input logic [7:0] e, input string what);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1 chk(what, REG_RDATA, e);
    endtask
    // counter request pulse {ret, jump, call, add, step}
    task pc_op(input logic [4:0] v, input logic [9:0] o, input logic [11:0] t,
        input logic [7:0] a);
        @(posedge CORE_CLK);
        {PC_RET, PC_JUMP, PC_CALL, PC_ADD, PC_STEP} <= v;
        OPERAND <= o;
        STACK_TOP <= t;
        ACC <= a;
        #1 pushv = {STACK_PUSH, STACK_PUSH_ADDR};
        @(posedge CORE_CLK);
        {PC_RET, PC_JUMP, PC_CALL, PC_ADD, PC_STEP} <= 5'h0;
        #1;
    endtask
    // status event pulse {clear, reset pin, sleep, timeout}
    task ev(input logic [3:0] v, input logic s);
        @(posedge CORE_CLK);
        {WDT_CLEAR_EXEC, RESET_PIN_EVENT, SLEEP_EXEC, WDT_TIMEOUT} <= v;
        SLEEPING <= s;
        @(posedge CORE_CLK);
        {WDT_CLEAR_EXEC, RESET_PIN_EVENT, SLEEP_EXEC, WDT_TIMEOUT} <= 4'h0;
    endtask
    // hang guard
    initial begin
        repeat (4000) @(posedge CORE_CLK);
        n_fail++;
        stop_test;
    end
    initial begin
        repeat (5) @(posedge CORE_CLK);
        RST <= 1'b0;
        #1 chk("pc reset", PC, 12'h000);
        rd(6'h03, 8'h18, "status reset");
        for (int i = 0; i < 7; i++) begin
            ev(evv[i], sl[i]);
            rd(6'h03, stx[i], "status event");
        end
        wr(6'h03, 8'hff);
        rd(6'h03, 8'h7f, "status write");
        wr(6'h03, 8'h67, 1'b1);
        rd(6'h03, 8'h7a, "flag update");
        // page 1, then jump, step wraps to the page start, call, return
        wr(6'h03, 8'h20);
        pc_op(5'h08, 10'h3ff, 12'h000, 8'h00);
        chk("jump", PC, 12'h7ff);
        pc_op(5'h01, 10'h000, 12'h000, 8'h00);
        chk("step", PC, 12'h400);
        pc_op(5'h04, 10'h155, 12'h000, 8'h00);
        chk("push", pushv, 13'h1401);
        chk("call", PC, 12'h555);
        wr(6'h03, 8'h60);
        pc_op(5'h18, 10'h000, 12'h401, 8'h00);
        chk("return", PC, 12'h401);
        wr(6'h02, 8'hab);
        #1 chk("pc write", PC, 12'hcab);
        rd(6'h02, 8'hab, "pc low");
        pc_op(5'h02, 10'h000, 12'h000, 8'h60);
        chk("pc add", PC, 12'hd0b);
        // pointer, indirect slot and display ram
        wr(6'h04, 8'h4a);
        #1 chk("bank", BANK_SEL, 2'b01);
        wr(6'h00, 8'h05);
        wr(6'h04, 8'h4b);
        wr(6'h00, 8'h0c);
        rd(6'h0b, 8'h0c, "display data");
        rd(6'h00, 8'h0c, "indirect read");
        rd(6'h0a, 8'h05, "display address");
        rd(6'h04, 8'h4b, "pointer");
        wr(6'h0a, 8'hff);
        rd(6'h0a, 8'h1f, "address mask");
        wr(6'h0b, 8'hf3);
        rd(6'h0b, 8'h03, "data mask");
        wr(6'h04, 8'h90);
        rd(6'h00, 8'h6f, "indirect bank");
        wr(6'h20, 8'h5a);
        rd(6'h20, 8'h5a, "bank ram");
        wr(6'h04, 8'h00);
        rd(6'h00, 8'h00, "null slot");
        // ports as outputs, then ports 6 to 8 as inputs
        wr(6'h05, 8'h91);
        rd(6'h05, 8'h91, "port5 page");
        for (int p = 6; p < 9; p++) begin
            wr(p[5:0], 8'ha5 ^ p[7:0]);
            rd(p[5:0], 8'ha5 ^ p[7:0], "port latch");
        end
        chk("port pins", {CTRL_PAGE, PORT_OUT}, 29'h1ada2a39);
        @(posedge CORE_CLK);
        PIN_DIR <= 28'hffffff0;
        PIN_EXT <= 28'h5c3a960;
        repeat (5) @(posedge CORE_CLK);
        for (int p = 6; p < 9; p++) begin
            rd(p[5:0], PIN_EXT[p * 8 - 44 +: 8], "port input");
        end
        // every duty and frame code, bias/type/enable varied alongside
        for (int d = 0; d < 4; d++) begin
            for (int f = 0; f < 4; f++) begin
                cv = {f[0], d[1:0], d[0], 1'b1, f[1], f[1:0]};
                nc = d[1] ? 3'h4 : 3'(d + 2);
                k = (nc - 2) * 4 + f;
                wr(6'h09, cv);
                @(posedge CORE_CLK);
                #1 chk("lcd", lcd_o, {f[0], d[0], f[1], nc, 11'(nv[k] * nc)});
                rd(6'h09, cv & 8'hf7, "lcd control");
            end
        end
        // scan read while enabled, then forced low
        wr(6'h09, 8'h10);
        wr(6'h0a, 8'h03);
        wr(6'h0b, 8'h09);
        @(posedge CORE_CLK);
        SCAN_ADDR <= 5'h03;
        repeat (2) @(posedge CORE_CLK);
        #1 chk("scan", SCAN_DATA, 4'h9);
        wr(6'h09, 8'h00);
        repeat (2) @(posedge CORE_CLK);
        #1 chk("scan off", SCAN_DATA, 4'h0);
        stop_test;
    end
endmodule // test_core_operational_registers

/* File: hdl/corr_defs.vh */
// constants for the core operational register bank
`ifndef CORR_DEFS_VH
`define CORR_DEFS_VH
// register addresses
`define CORR_A_IND 6'h00
`define CORR_A_PC 6'h02
`define CORR_A_STAT 6'h03
`define CORR_A_PTR 6'h04
`define CORR_A_P5 6'h05
`define CORR_A_P6 6'h06
`define CORR_A_P7 6'h07
`define CORR_A_P8 6'h08
`define CORR_A_LCTL 6'h09
`define CORR_A_LADR 6'h0a
`define CORR_A_LDAT 6'h0b
// status field positions
`define CORR_ST_PS_HI 6
`define CORR_ST_PS_LO 5
`define CORR_ST_TO 4
`define CORR_ST_PD 3
`define CORR_ST_Z 2
`define CORR_ST_DC 1
`define CORR_ST_C 0
// display control field positions
`define CORR_LC_BIAS 7
`define CORR_LC_DUTY_HI 6
`define CORR_LC_DUTY_LO 5
`define CORR_LC_EN 4
`define CORR_LC_TYPE 2
`define CORR_LC_FR_HI 1
`define CORR_LC_FR_LO 0
// reset values
`define CORR_RST_STAT 8'h18
`define CORR_RST_BYTE 8'h00
`define CORR_RST_PC 12'h000
// frame divisor N per duty and frame field
`define CORR_N_D2_0 9'h100
`define CORR_N_D2_1 9'h118
`define CORR_N_D2_2 9'h130
`define CORR_N_D2_3 9'h0e8
`define CORR_N_D3_0 9'h0ac
`define CORR_N_D3_1 9'h0bc
`define CORR_N_D3_2 9'h0cc
`define CORR_N_D3_3 9'h09c
`define CORR_N_D4_0 9'h080
`define CORR_N_D4_1 9'h08c
`define CORR_N_D4_2 9'h098
`define CORR_N_D4_3 9'h074
// number of commons per duty
`define CORR_COM_2 3'h2
`define CORR_COM_3 3'h3
`define CORR_COM_4 3'h4
`endif

/* File: hdl/corr_regs.v */
// core operational register bank: counter, status, pointer, ports, display
`timescale 1ns/1ps
`include "corr_defs.vh"
module corr_regs #(
    parameter PC_W = 12, // counter width
    parameter OPD_W = 10, // jump operand width
    parameter NPIN = 28, // port bits: p5[7:4], p6, p7, p8
    parameter DRAM_N = 32 // display ram entries
) (
    // clock and power-up reset
    input wire CORE_CLK,
    input wire RST,
    // register bus from the instruction side
    input wire [5:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    // banked data ram beyond the local range
    output wire [7:0] RAM_ADDR,
    output wire RAM_WR,
    output wire RAM_RD,
    output wire [7:0] RAM_WDATA,
    input wire [7:0] RAM_RDATA,
    // counter requests and the hardware stack
    input wire PC_STEP,
    input wire PC_JUMP,
    input wire PC_CALL,
    input wire PC_RET,
    input wire PC_ADD,
    input wire [7:0] ACC,
    input wire [OPD_W-1:0] OPERAND,
    input wire [PC_W-1:0] STACK_TOP,
    output wire STACK_PUSH,
    output wire [PC_W-1:0] STACK_PUSH_ADDR,
    output wire [PC_W-1:0] PC,
    // alu flags and wake events
    input wire FLAG_WE,
    input wire [2:0] FLAG_IN,
    input wire SLEEP_EXEC,
    input wire WDT_CLEAR_EXEC,
    input wire WDT_TIMEOUT,
    input wire RESET_PIN_EVENT,
    input wire SLEEPING,
    // port pins and their directions
    input wire [NPIN-1:0] PIN_IN,
    input wire [NPIN-1:0] PIN_DIR,
    output reg [NPIN-1:0] PORT_OUT,
    // page, bank and display controls
    output wire CTRL_PAGE,
    output wire [1:0] BANK_SEL,
    output wire LCD_ENABLE,
    output wire LCD_BIAS_THIRD,
    output wire [2:0] LCD_COMMONS,
    output wire LCD_TYPE_B,
    output reg [10:0] LCD_FRAME_DIV,
    // display ram scan for the waveform side
    input wire [4:0] SCAN_ADDR,
    output reg [3:0] SCAN_DATA
);
    // architectural state
    reg [PC_W-1:0] pc_q; // program counter
    reg [PC_W-1:0] pc_d;
    reg [7:0] stat_q; // status flags
    reg [7:0] stat_d;
    reg [7:0] ptr_q; // bank and indirect pointer
    reg ctl_page_q; // control register page select
    reg [7:0] lctl_q; // display control
    reg [4:0] ladr_q; // display ram address
    reg [3:0] dram [0:DRAM_N-1]; // display ram
    wire [NPIN-1:0] pin_s; // filtered levels on input bits, latch on output bits

    // indirect access redirects through the pointer
    wire is_ind = (REG_ADDR == `CORR_A_IND);
    wire [5:0] eff = is_ind ? ptr_q[5:0] : REG_ADDR;
    // locally held addresses
    wire local_hit = (eff >= `CORR_A_PC) && (eff <= `CORR_A_LDAT);
    // pointing back at the indirect slot reads zero, writes nothing
    wire null_hit = (eff == `CORR_A_IND);
    wire wr = REG_WR && local_hit;
    wire [1:0] ps = {stat_q[`CORR_ST_PS_HI], stat_q[`CORR_ST_PS_LO]};

    // outside data memory gets bank plus index
    assign RAM_ADDR = {ptr_q[7:6], eff};
    // strobes pass out only off the local range
    assign RAM_WR = REG_WR && !local_hit && !null_hit;
    assign RAM_RD = REG_RD && !local_hit && !null_hit;
    assign RAM_WDATA = REG_WDATA;
    assign BANK_SEL = ptr_q[7:6];
    assign PC = pc_q;
    assign CTRL_PAGE = ctl_page_q;

    // call pushes the address of the next instruction
    assign STACK_PUSH = PC_CALL;
    assign STACK_PUSH_ADDR = pc_q + {{(PC_W-1){1'b0}}, 1'b1};

    // next program counter
    always @* begin
        // hold unless a request comes
        pc_d = pc_q;
        if (PC_RET) begin
            // whole counter from stack, page bits included
            pc_d = STACK_TOP;
        end else if (PC_JUMP || PC_CALL) begin
            // page bits on top, operand below
            pc_d = {ps, OPERAND};
        end else if (PC_ADD) begin
            // relative offset, page from status
            pc_d = {ps, pc_q[9:0] + {2'b00, ACC}};
        end else if (wr && eff == `CORR_A_PC) begin
            // low byte from data, bits eight and nine kept, page from status
            pc_d = {ps, pc_q[9:8], REG_WDATA};
        end else if (PC_STEP) begin
            // sequential step within the current page
            pc_d = {pc_q[11:10], pc_q[9:0] + 10'h001};
        end
    end

    // counter register
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            // counter starts at the reset vector
            pc_q <= `CORR_RST_PC;
        end else begin
            // take the next value
            pc_q <= pc_d;
        end
    end

    // next status: page and alu flags writable, wake bits by events
    always @* begin
        // hold unless a write or event
        stat_d = stat_q;
        if (wr && eff == `CORR_A_STAT) begin
            // software writes page and flags, wake bits read-only
            stat_d[`CORR_ST_PS_HI] = REG_WDATA[`CORR_ST_PS_HI];
            stat_d[`CORR_ST_PS_LO] = REG_WDATA[`CORR_ST_PS_LO];
            stat_d[2:0] = REG_WDATA[2:0];
        end
        if (FLAG_WE) begin
            // alu result flags: zero, nibble carry, carry
            stat_d[`CORR_ST_Z] = FLAG_IN[2];
            stat_d[`CORR_ST_DC] = FLAG_IN[1];
            stat_d[`CORR_ST_C] = FLAG_IN[0];
        end
        // watchdog timeout clears time-out; power-down keeps its value
        if (WDT_TIMEOUT) begin
            stat_d[`CORR_ST_TO] = 1'b0;
        end
        // sleep: time-out set, power-down cleared
        if (SLEEP_EXEC) begin
            stat_d[`CORR_ST_TO] = 1'b1;
            stat_d[`CORR_ST_PD] = 1'b0;
        end
        // reset pin: wake from sleep gives 10, plain pulse gives 11
        if (RESET_PIN_EVENT) begin
            stat_d[`CORR_ST_TO] = 1'b1;
            stat_d[`CORR_ST_PD] = !SLEEPING;
        end
        // watchdog clear sets both, wins over other events
        if (WDT_CLEAR_EXEC) begin
            stat_d[`CORR_ST_TO] = 1'b1;
            stat_d[`CORR_ST_PD] = 1'b1;
        end
        // top bit reads zero whatever was written
        stat_d[7] = 1'b0; // unused bit
    end

    // status register, power-up gives 11 in the wake pair
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            // wake pair starts at 11
            stat_q <= `CORR_RST_STAT;
        end else begin
            // take the next value
            stat_q <= stat_d;
        end
    end

    // pointer, port, display control and address registers
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            // every latch starts cleared
            ptr_q <= `CORR_RST_BYTE;
            ctl_page_q <= 1'b0;
            PORT_OUT <= {NPIN{1'b0}};
            lctl_q <= `CORR_RST_BYTE;
            ladr_q <= 5'h00;
        end else if (wr) begin
            // a write lands at the strobe edge
            case (eff)
                // plain storage when not used for indirection
                `CORR_A_PTR: begin
                    ptr_q <= REG_WDATA;
                end
                // port5 nibble and control page
                `CORR_A_P5: begin
                    PORT_OUT[3:0] <= REG_WDATA[7:4];
                    ctl_page_q <= REG_WDATA[0];
                end
                // full-byte port latches
                `CORR_A_P6: begin
                    // port 6 latch
                    PORT_OUT[11:4] <= REG_WDATA;
                end
                `CORR_A_P7: begin
                    // port 7 latch
                    PORT_OUT[19:12] <= REG_WDATA;
                end
                `CORR_A_P8: begin
                    // port 8 latch
                    PORT_OUT[27:20] <= REG_WDATA;
                end
                // display control, bit3 unused
                `CORR_A_LCTL: begin
                    lctl_q <= REG_WDATA & 8'hf7;
                end
                // display address, five bits kept
                `CORR_A_LADR: begin
                    ladr_q <= REG_WDATA[4:0];
                end
                default: begin
                    // other local addresses hold nothing here
                    ptr_q <= ptr_q;
                end
            endcase
        end
    end

    // display ram write through the data buffer
    always @(posedge CORE_CLK) begin
        if (wr && eff == `CORR_A_LDAT) begin
            // low nibble only; this array has no reset
            dram[ladr_q] <= REG_WDATA[3:0];
        end
    end

    // pin inputs: three stages, change taken when stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
            reg s1_q; // first stage, feeds second only
            reg s2_q;
            reg s3_q;
            reg lvl_q; // accepted level
            always @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    // filter starts low
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    lvl_q <= 1'b0;
                end else begin
                    // shift the pin through three stages
                    s1_q <= PIN_IN[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // accept once stages two and three agree
                    if (s2_q == s3_q) begin
                        lvl_q <= s3_q;
                    end
                end
            end
            // input bits read the pin, output bits read the latch
            assign pin_s[gi] = PIN_DIR[gi] ? lvl_q : PORT_OUT[gi];
        end
    endgenerate

    // register read, answered one cycle after the strobe
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            // nothing read yet
            REG_RDATA <= `CORR_RST_BYTE;
        end else if (REG_RD) begin
            if (null_hit) begin
                // self-pointing indirect slot
                REG_RDATA <= 8'h00;
            end else if (!local_hit) begin
                // banked data ram, valid in the strobe cycle
                REG_RDATA <= RAM_RDATA;
            end else begin
                case (eff)
                    `CORR_A_PC: begin
                        // counter low byte
                        REG_RDATA <= pc_q[7:0];
                    end
                    `CORR_A_STAT: begin
                        // page, wake pair and alu flags
                        REG_RDATA <= stat_q;
                    end
                    `CORR_A_PTR: begin
                        // bank and index
                        REG_RDATA <= ptr_q;
                    end
                    `CORR_A_P5: begin
                        // port 5 nibble and page bit
                        REG_RDATA <= {pin_s[3:0], 3'b000, ctl_page_q};
                    end
                    `CORR_A_P6: begin
                        // port 6 pins or latch
                        REG_RDATA <= pin_s[11:4];
                    end
                    `CORR_A_P7: begin
                        // port 7 pins or latch
                        REG_RDATA <= pin_s[19:12];
                    end
                    `CORR_A_P8: begin
                        // port 8 pins or latch
                        REG_RDATA <= pin_s[27:20];
                    end
                    `CORR_A_LCTL: begin
                        // display control byte
                        REG_RDATA <= lctl_q;
                    end
                    `CORR_A_LADR: begin
                        // display address, top bits zero
                        REG_RDATA <= {3'b000, ladr_q};
                    end
                    `CORR_A_LDAT: begin
                        // addressed display entry
                        REG_RDATA <= {4'h0, dram[ladr_q]};
                    end
                    default: begin
                        // unreachable local slot
                        REG_RDATA <= 8'h00;
                    end
                endcase
            end
        end
    end

    // display control decode
    wire [1:0] duty = {lctl_q[`CORR_LC_DUTY_HI], lctl_q[`CORR_LC_DUTY_LO]};
    wire [1:0] frame = {lctl_q[`CORR_LC_FR_HI], lctl_q[`CORR_LC_FR_LO]};
    assign LCD_ENABLE = lctl_q[`CORR_LC_EN];
    assign LCD_BIAS_THIRD = lctl_q[`CORR_LC_BIAS];
    assign LCD_TYPE_B = lctl_q[`CORR_LC_TYPE];
    // quarter duty whenever the upper duty bit is set
    assign LCD_COMMONS = duty[1] ? `CORR_COM_4 :
                         (duty[0] ? `CORR_COM_3 : `CORR_COM_2);

    // divisor N from duty and frame field
    reg [8:0] n_sel;
    always @* begin
        n_sel = `CORR_N_D2_0;
        case ({duty[1], duty[1] ? 1'b0 : duty[0], frame})
            // half duty
            4'h0: n_sel = `CORR_N_D2_0;
            4'h1: n_sel = `CORR_N_D2_1;
            4'h2: n_sel = `CORR_N_D2_2;
            4'h3: n_sel = `CORR_N_D2_3;
            // third duty
            4'h4: n_sel = `CORR_N_D3_0;
            4'h5: n_sel = `CORR_N_D3_1;
            4'h6: n_sel = `CORR_N_D3_2;
            4'h7: n_sel = `CORR_N_D3_3;
            // quarter duty
            4'h8: n_sel = `CORR_N_D4_0;
            4'h9: n_sel = `CORR_N_D4_1;
            4'ha: n_sel = `CORR_N_D4_2;
            4'hb: n_sel = `CORR_N_D4_3;
            default: n_sel = `CORR_N_D2_0;
        endcase
    end

    // frame divisor and scan port, scan forced low when disabled
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            LCD_FRAME_DIV <= 11'h000;
            SCAN_DATA <= 4'h0;
        end else begin
            // divisor follows the control byte a cycle later
            LCD_FRAME_DIV <= n_sel * {8'h00, LCD_COMMONS};
            SCAN_DATA <= LCD_ENABLE ? dram[SCAN_ADDR] : 4'h0;
        end
    end
endmodule // corr_regs
